// ### hdl/crsc_pkg.sv
package crsc_pkg;
    // field widths
    localparam int SPD_W = 20;                  // speed in hz, up to 1,000,000
    localparam int RMP_W = 20;                  // ramp setting, up to 1,000,000
    localparam int SEL_W = 6;                   // operation-data select bits
    localparam int N_ENTRY = 64;                // number of operation-data entries
    localparam int ACC_W = 32;                  // ramp accumulator width
    localparam int ADDR_W = 12;                 // avalon byte address width

    // reset values
    localparam logic [SPD_W-1:0] SPEED_RST = 20'h003e8;   // 1,000 hz
    localparam logic [RMP_W-1:0] RAMP_RST = 20'h003e8;    // 1,000 counts
    localparam logic [SPD_W-1:0] START_RST = 20'h001f4;   // starting speed 500 hz
    localparam logic [RMP_W-1:0] RAMP_MIN = 20'h00001;    // smallest legal ramp setting

    // timing: ramp settings count in 0.001 ms (rate) or 0.001 s (time)
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
    localparam logic [ACC_W-1:0] RATE_NUM = 32'h000003e8;  // 1,000 hz per khz-step scaling
    localparam logic [9:0] TIME_SCALE = 10'h3e8;           // 1 count = 1,000 ticks of 1 us

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;      // bit0 common ramps, bit1 time units
    localparam logic [ADDR_W-1:0] OFS_START = 12'h004;     // starting speed
    localparam logic [ADDR_W-1:0] OFS_CACC = 12'h008;      // shared accel setting
    localparam logic [ADDR_W-1:0] OFS_CDEC = 12'h00c;      // shared decel setting
    localparam logic [ADDR_W-1:0] OFS_STAT = 12'h010;      // read-only status
    localparam logic [ADDR_W-1:0] OFS_SPEED = 12'h014;     // read-only current speed
    localparam logic [1:0] PAGE_SPD = 2'h1;                // 0x100: entry speeds
    localparam logic [1:0] PAGE_ACC = 2'h2;                // 0x200: entry accels
    localparam logic [1:0] PAGE_DEC = 2'h3;                // 0x300: entry decels
    localparam int CTRL_COMMON = 0;
    localparam int CTRL_TIME = 1;

    // run states, gray along idle -> run -> stopping -> blocked
    typedef enum logic [1:0] {
        CRSC_IDLE = 2'h0,
        CRSC_RUN = 2'h1,
        CRSC_STOP = 2'h3,
        CRSC_BLOCK = 2'h2
    } crsc_state_t;

    // pin request bundle
    typedef struct packed {
        logic forward_run_request;
        logic reverse_run_request;
        logic [SEL_W-1:0] sel;
    } crsc_req_t;

    // motion status bundle
    typedef struct packed {
        logic ready;
        logic move;
        logic dir_rvs;
        logic [SPD_W-1:0] speed;
    } crsc_motion_t;
endpackage : crsc_pkg

// ### hdl/crsc_speed_ctrl.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module crsc_speed_ctrl
    import crsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire crsc_req_t pin_req,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output crsc_motion_t motion
);

    // decode of the six select bits into an entry number
    function automatic logic [SEL_W-1:0] entry_of(input crsc_req_t r);
        entry_of = r.sel;
    endfunction : entry_of

    // two-flop synchronisers; stage one is read by stage two only
    crsc_req_t req_m;
    crsc_req_t req_s;
    crsc_req_t req_q;          // registered copy used by logic
    // configuration
    logic [SPD_W-1:0] spd_mem [N_ENTRY];
    logic [RMP_W-1:0] acc_mem [N_ENTRY];
    logic [RMP_W-1:0] dec_mem [N_ENTRY];
    logic common_r;            // shared ramps
    logic time_r;              // ramps in time units
    logic [SPD_W-1:0] start_r;
    logic [RMP_W-1:0] cacc_r;
    logic [RMP_W-1:0] cdec_r;
    // motion
    crsc_state_t state_r;
    logic dir_r;               // 1 = reverse
    logic conflict_r;          // stop caused by both requests
    logic [SPD_W-1:0] speed_r;
    logic [ACC_W-1:0] acc_r;
    logic [7:0] tick_cnt_r;
    logic tick;
    // bus
    logic ack_r;
    logic [31:0] rdata_r;

    // input synchroniser
    // synchronised sampling
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            req_m <= '0;
            req_s <= '0;
            req_q <= '0;
        end
        else
        begin
            req_m <= pin_req;
            req_s <= req_m;
            req_q <= req_s;
        end
    end

    // request decode
    logic both;
    logic any_one;
    logic req_dir;             // direction asked when only one is high
    logic same_only;           // only the running direction is requested
    logic [SEL_W-1:0] idx;
    assign both = req_q.forward_run_request & req_q.reverse_run_request;
    assign any_one = req_q.forward_run_request ^ req_q.reverse_run_request;
    assign req_dir = req_q.reverse_run_request;
    assign same_only = any_one && (req_dir == dir_r);
    assign idx = entry_of(req_q);

    // selected entry and ramp source
    logic [SPD_W-1:0] entry_spd;
    logic [RMP_W-1:0] up_set;
    logic [RMP_W-1:0] down_set;
    assign entry_spd = spd_mem[idx];
    assign up_set = common_r ? cacc_r : acc_mem[idx];
    assign down_set = common_r ? cdec_r : dec_mem[idx];

    // microsecond tick divider
    always_ff @(posedge clk_sys)
    begin
        if (srst || tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 8'h01;
    end
    assign tick = (tick_cnt_r == TICK_LAST);

    // speed target: entry speed while running, starting speed while stopping
    logic [SPD_W-1:0] target;
    logic going_up;
    logic at_target;
    logic at_floor;
    assign target = (state_r == CRSC_RUN) ? entry_spd : start_r;
    assign going_up = (speed_r < target);
    assign at_target = (speed_r == target);
    assign at_floor = (speed_r <= start_r);

    // ramp step rate: num added per tick, one hz per den consumed
    logic [RMP_W-1:0] ramp_set;
    logic [SPD_W-1:0] delta_v;
    logic [ACC_W-1:0] num;
    logic [ACC_W-1:0] den;
    logic [ACC_W-1:0] acc_sum;
    // accel setting up, decel setting down
    assign ramp_set = going_up ? up_set : down_set;
    // delta is the distance between entry speed and starting speed, whichever is larger
    assign delta_v = (entry_spd > start_r) ? entry_spd - start_r : start_r - entry_spd;
    always_comb
    begin
        if (time_r)
        begin
            // hz per us = delta / (setting * 1,000 us)
            num = (delta_v == '0) ? 32'h00000001 : ACC_W'(delta_v);
            den = ACC_W'(ramp_set) * ACC_W'(TIME_SCALE);
        end
        else
        begin
            // setting us per khz: 1,000 hz per setting us
            num = RATE_NUM;
            den = ACC_W'(ramp_set);
        end
    end
    assign acc_sum = tick ? acc_r + num : acc_r;

    // ramp accumulator and speed; one hz step per clock at most
    // limitation: slope saturates at 100 hz per us (100 khz per ms)
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            speed_r <= '0;
            acc_r <= '0;
        end
        else if (state_r == CRSC_IDLE || state_r == CRSC_BLOCK)
        begin
            // every start begins at starting speed
            speed_r <= (state_r == CRSC_IDLE && any_one) ? start_r : '0;
            acc_r <= '0;
        end
        else if (state_r == CRSC_STOP && at_floor)
        begin
            // floor reached: stop or restart at starting speed
            speed_r <= (!conflict_r && any_one && !both) ? start_r : '0;
            acc_r <= '0;
        end
        else if (at_target)
            acc_r <= '0;
        else if (acc_sum >= den)
        begin
            acc_r <= acc_sum - den;
            speed_r <= going_up ? speed_r + 20'h00001 : speed_r - 20'h00001;
        end
        else
            acc_r <= acc_sum;
    end

    // run state machine
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_r <= CRSC_IDLE;
            dir_r <= 1'b0;
            conflict_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                CRSC_IDLE:
                begin
                    conflict_r <= 1'b0;
                    if (both)
                        state_r <= CRSC_BLOCK;
                    else if (any_one)
                    begin
                        // select taken from the same sample
                        state_r <= CRSC_RUN;
                        dir_r <= req_dir;
                    end
                end
                CRSC_RUN:
                begin
                    if (both)
                    begin
                        state_r <= CRSC_STOP;
                        conflict_r <= 1'b1;
                    end
                    else if (!same_only)
                        state_r <= CRSC_STOP;
                end
                CRSC_STOP:
                begin
                    if (both)
                        conflict_r <= 1'b1;
                    if (at_floor)
                    begin
                        if (conflict_r || both)
                            state_r <= CRSC_BLOCK;
                        else if (any_one)
                        begin
                            // stopped, now run in the requested direction
                            state_r <= CRSC_RUN;
                            dir_r <= req_dir;
                        end
                        else
                            state_r <= CRSC_IDLE;
                    end
                    else if (same_only && !conflict_r)
                        state_r <= CRSC_RUN;
                end
                CRSC_BLOCK:
                begin
                    if (!req_q.forward_run_request && !req_q.reverse_run_request)
                        state_r <= CRSC_IDLE;
                end
            endcase
        end
    end

    // outputs
    // ready only while idle
    // one driver for the whole bundle: {ready, move, dir_rvs, speed}
    assign motion = {state_r == CRSC_IDLE, (state_r == CRSC_RUN) || (state_r == CRSC_STOP), dir_r, speed_r};

    // avalon slave: every access answers at its second edge
    logic req_bus;
    logic [1:0] page;
    logic [5:0] widx;
    logic [RMP_W-1:0] wval;
    assign req_bus = avs_read | avs_write;
    assign avs_waitrequest = req_bus & ~ack_r;
    assign page = avs_address[9:8];
    assign widx = avs_address[7:2];
    // zero ramp settings would step one hz every clock, so store at least one
    assign wval = (avs_writedata[RMP_W-1:0] == '0) ? RAMP_MIN : avs_writedata[RMP_W-1:0];

    // acknowledge pulse
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            ack_r <= 1'b0;
        else
            ack_r <= req_bus & ~ack_r;
    end

    // register writes take effect at the acknowledging edge
    // entry speeds, entry ramps, default 1,000
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            common_r <= 1'b0;
            time_r <= 1'b0;
            start_r <= START_RST;
            cacc_r <= RAMP_RST;
            cdec_r <= RAMP_RST;
            for (int i = 0; i < N_ENTRY; i++)
            begin
                spd_mem[i] <= SPEED_RST;
                acc_mem[i] <= RAMP_RST;
                dec_mem[i] <= RAMP_RST;
            end
        end
        else if (avs_write && ack_r && avs_address[11:10] == 2'h0)
        begin
            if (page == 2'h0)
            begin
                // global registers; unmapped offsets ignored
                if (avs_address == OFS_CTRL)
                begin
                    common_r <= avs_writedata[CTRL_COMMON];
                    time_r <= avs_writedata[CTRL_TIME];
                end
                if (avs_address == OFS_START)
                    start_r <= avs_writedata[SPD_W-1:0];
                if (avs_address == OFS_CACC)
                    cacc_r <= wval;
                if (avs_address == OFS_CDEC)
                    cdec_r <= wval;
            end
            else if (page == PAGE_SPD)
                spd_mem[widx] <= wval;
            else if (page == PAGE_ACC)
                acc_mem[widx] <= wval;
            else
                dec_mem[widx] <= wval;
        end
    end

    // read data captured at the first edge, held through the second
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rdata_r <= '0;
        else if (avs_read && !ack_r)
        begin
            rdata_r <= '0;
            if (avs_address[11:10] == 2'h0)
            begin
                if (page == PAGE_SPD)
                    rdata_r <= {12'h000, spd_mem[widx]};
                else if (page == PAGE_ACC)
                    rdata_r <= {12'h000, acc_mem[widx]};
                else if (page == PAGE_DEC)
                    rdata_r <= {12'h000, dec_mem[widx]};
                else if (avs_address == OFS_CTRL)
                    rdata_r <= {30'h00000000, time_r, common_r};
                else if (avs_address == OFS_START)
                    rdata_r <= {12'h000, start_r};
                else if (avs_address == OFS_CACC)
                    rdata_r <= {12'h000, cacc_r};
                else if (avs_address == OFS_CDEC)
                    rdata_r <= {12'h000, cdec_r};
                else if (avs_address == OFS_STAT)
                    rdata_r <= {21'h000000, idx, state_r == CRSC_STOP, conflict_r, dir_r,
                                motion.move, motion.ready};
                else if (avs_address == OFS_SPEED)
                    rdata_r <= {12'h000, speed_r};
            end
        end
    end
    assign avs_readdata = rdata_r;

    // assertions
    property p_start_run;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_IDLE && any_one) |=> (!motion.ready && motion.move);
    endproperty
    a_start_run: assert property (p_start_run) else $error("start did not drop ready");

    property p_start_speed;
        @(posedge clk_sys) disable iff (srst)
        $rose(motion.move) |-> (speed_r == start_r);
    endproperty
    a_start_speed: assert property (p_start_speed) else $error("start not at starting speed");

    property p_conflict_stop;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_RUN && both) |=> (state_r == CRSC_STOP && conflict_r);
    endproperty
    a_conflict_stop: assert property (p_conflict_stop) else $error("both requests not stopping");

    property p_release_stop;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_RUN && !req_q.forward_run_request && !req_q.reverse_run_request) |=> (state_r == CRSC_STOP);
    endproperty
    a_release_stop: assert property (p_release_stop) else $error("release did not decelerate");

    property p_reaccel;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_STOP && !at_floor && same_only && !conflict_r && !both)
            |=> (state_r == CRSC_RUN);
    endproperty
    a_reaccel: assert property (p_reaccel) else $error("same request did not reaccelerate");

    property p_ready_back;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_STOP && at_floor && !conflict_r && !req_q.forward_run_request && !req_q.reverse_run_request)
            |=> (motion.ready && !motion.move);
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not back after stop");

    property p_block_still;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_BLOCK) |-> (!motion.move && speed_r == '0);
    endproperty
    a_block_still: assert property (p_block_still) else $error("motion after conflict stop");

    property p_block_ready;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_BLOCK && (req_q.forward_run_request || req_q.reverse_run_request)) |=> !motion.ready;
    endproperty
    a_block_ready: assert property (p_block_ready) else $error("ready while request held");

    property p_reverse;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_STOP && at_floor && !conflict_r && any_one && !same_only)
            |=> (state_r == CRSC_RUN && dir_r != $past(dir_r) && speed_r == start_r);
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse not after stop");

    property p_ramp_up;
        @(posedge clk_sys) disable iff (srst)
        (state_r == CRSC_RUN && going_up && $stable(idx)) |=> (speed_r >= $past(speed_r));
    endproperty
    a_ramp_up: assert property (p_ramp_up) else $error("speed fell while accelerating");

    c_run: cover property (@(posedge clk_sys) disable iff (srst) state_r == CRSC_RUN && at_target);
    c_reaccel: cover property (@(posedge clk_sys) disable iff (srst)
        state_r == CRSC_STOP ##1 state_r == CRSC_RUN);
    c_block: cover property (@(posedge clk_sys) disable iff (srst)
        state_r == CRSC_BLOCK ##1 state_r == CRSC_IDLE);

endmodule : crsc_speed_ctrl

// ### tb/crsc_host_model.sv
`timescale 1ns/1ps
// host side: pins follow bench commands, keeping the start order
module crsc_host_model
    import crsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire crsc_motion_t motion,
    input wire crsc_req_t cmd,
    input wire logic same_upd,
    output crsc_req_t pin_req
);
    logic idle_pins; // no direction request on the pins
    logic may_start; // a fresh start is allowed now
    assign idle_pins = !pin_req.forward_run_request && !pin_req.reverse_run_request;
    assign may_start = (motion.ready || motion.move) && (same_upd || pin_req.sel == cmd.sel);
    // pins change just after the edge, like real host outputs
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pin_req <= '0;
        end
        else
        begin
            pin_req.sel <= cmd.sel;
            // a running request follows at once, a start may wait
            if (!idle_pins || may_start)
            begin
                pin_req.forward_run_request <= cmd.forward_run_request;
                pin_req.reverse_run_request <= cmd.reverse_run_request;
            end
        end
    end
endmodule : crsc_host_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module tb_top
    import crsc_pkg::*;
;
    logic clk_sys; // 100 mhz system clock
    logic srst; // synchronous reset
    crsc_req_t cmd; // wanted pin state
    logic same_upd; // select and direction in one update
    crsc_req_t pin_req; // pins from the host model
    crsc_motion_t motion; // status outputs
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] rd_q[$]; // expected read data, oldest first
    logic [31:0] rd_exp;
    int fail_count;
    int n_tests;
    int seed;
    int ent[3] = '{0, 1, 33}; // entries given fast ramps
    logic [19:0] spd[3]; // their speeds
    // free running clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    crsc_speed_ctrl dut (.clk_sys(clk_sys), .srst(srst), .pin_req(pin_req), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .motion(motion));
    crsc_host_model host (.clk_sys(clk_sys), .srst(srst), .motion(motion), .cmd(cmd),
        .same_upd(same_upd), .pin_req(pin_req));
    // verdict, reached from the main flow or a spent wait
    task final_report;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // one avalon transfer; a read notes its expected data
    task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        if (!wr)
            rd_q.push_back(d);
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 50)
        begin
            fail_count++;
            $display("unexpected waitrequest: expected 0, seen 1");
            final_report();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // read data checked at the edge where the slave answers
    always @(posedge clk_sys)
    begin
        if (!srst && avs_read === 1'b1 && avs_waitrequest === 1'b0)
        begin
            rd_exp = rd_q.pop_front();
            `CHK("readdata", avs_readdata, rd_exp)
        end
    end
    // new pin wish, applied after an edge
    task go(input logic f, input logic r, input logic [5:0] s);
        @(posedge clk_sys);
        cmd <= {f, r, s};
    endtask : go
    // bounded wait for a status field: 0 speed, 1 ready, 2 move, 3 dir
    task wait_for(input int f, input logic [19:0] v);
        int i;
        logic [19:0] seen;
        for (i = 0; i < 4000; i++)
        begin
            @(posedge clk_sys);
            seen = (f == 0) ? motion.speed : (f == 1) ? 20'(motion.ready) :
                (f == 2) ? 20'(motion.move) : 20'(motion.dir_rvs);
            if (seen === v)
                break;
        end
        n_tests++;
        if (i == 4000)
        begin
            fail_count++;
            $display("unexpected field %0d: expected %h, seen %h", f, v, seen);
            final_report();
        end
    endtask : wait_for
    // main sequence
    initial
    begin
        int k;
        seed = 86977;
        fail_count = 0;
        n_tests = 0;
        srst = 1'b1;
        cmd = '0;
        same_upd = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        `CHK("ready", motion.ready, 1'b1)
        `CHK("speed", motion.speed, 20'h00000)
        bus(1'b0, OFS_START, 32'h000001f4);
        bus(1'b0, 12'h100, 32'h000003e8);
        bus(1'b0, 12'h2fc, 32'h000003e8);
        bus(1'b0, 12'h3fc, 32'h000003e8);
        bus(1'b1, 12'h400, 32'h00000005);
        bus(1'b0, 12'h018, 32'h00000000);
        bus(1'b1, OFS_CDEC, 32'h00000000);
        bus(1'b0, OFS_CDEC, 32'h00000001);
        $display("test registers done");
        // random speed kept inside the legal range
        spd[1] = 20'h002bc + 20'($random(seed) & 255);
        spd[0] = 20'h00258;
        spd[2] = 20'h00384;
        for (k = 0; k < 3; k++)
        begin
            bus(1'b1, 12'h100 + 12'(4 * ent[k]), 32'(spd[k]));
            bus(1'b1, 12'h200 + 12'(4 * ent[k]), 32'h00000001);
            bus(1'b1, 12'h300 + 12'(4 * ent[k]), 32'h00000001);
        end
        bus(1'b1, OFS_CACC, 32'h00000001);
        go(1'b1, 1'b0, 6'h01);
        wait_for(2, 20'h1);
        `CHK("start speed", motion.speed, 20'h001f4)
        `CHK("ready", motion.ready, 1'b0)
        `CHK("dir", motion.dir_rvs, 1'b0)
        wait_for(1, 20'h0);
        wait_for(0, spd[1]);
        go(1'b1, 1'b0, 6'h00);
        wait_for(0, spd[0]);
        go(1'b1, 1'b0, 6'h21);
        wait_for(0, spd[2]);
        go(1'b0, 1'b0, 6'h21);
        wait_for(1, 20'h1);
        `CHK("move", motion.move, 1'b0)
        `CHK("speed", motion.speed, 20'h00000)
        $display("test run done");
        go(1'b1, 1'b0, 6'h01);
        wait_for(0, spd[1]);
        go(1'b0, 1'b0, 6'h01);
        repeat (30) @(posedge clk_sys);
        go(1'b1, 1'b0, 6'h01);
        wait_for(0, spd[1]);
        `CHK("ready", motion.ready, 1'b0)
        go(1'b0, 1'b0, 6'h01);
        repeat (30) @(posedge clk_sys);
        go(1'b0, 1'b1, 6'h01);
        wait_for(3, 20'h1);
        `CHK("restart speed", motion.speed, 20'h001f4)
        wait_for(0, spd[1]);
        go(1'b1, 1'b1, 6'h01);
        wait_for(2, 20'h0);
        `CHK("ready", motion.ready, 1'b0)
        go(1'b0, 1'b1, 6'h01);
        repeat (50) @(posedge clk_sys);
        `CHK("ready", motion.ready, 1'b0)
        go(1'b0, 1'b0, 6'h01);
        wait_for(1, 20'h1);
        $display("test reversal done");
        // entry 2 keeps slow ramps, so only shared ones finish in time
        bus(1'b1, OFS_CTRL, 32'h00000001);
        same_upd <= 1'b1;
        go(1'b1, 1'b0, 6'h02);
        wait_for(0, 20'h003e8);
        go(1'b0, 1'b0, 6'h02);
        wait_for(1, 20'h1);
        $display("test common done");
        // time units: 500 hz over one ms, so about 5 hz per 1,000 cycles
        bus(1'b1, OFS_CTRL, 32'h00000003);
        bus(1'b0, OFS_CTRL, 32'h00000003);
        go(1'b1, 1'b0, 6'h02);
        wait_for(2, 20'h1);
        repeat (1000) @(posedge clk_sys);
        `CHK("time ramp", motion.speed >= 20'h001f7 && motion.speed <= 20'h001fa, 1'b1)
        go(1'b0, 1'b0, 6'h02);
        wait_for(1, 20'h1);
        $display("test time done");
        final_report();
    end
endmodule : tb_top
